// >>> logic/s3_quiesce.sv
`timescale 1ns/1ns
`default_nettype none

module s3_quiesce #(
  parameter int OUTSTANDING_W = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic s3_req_i,
  input wire s3_pkg::reg_req_s reg_i,
  output logic [s3_pkg::DATA_W-1:0] reg_rdata_o,
  input wire s3_pkg::sdram_cmd_e arb_cmd_i,
  input wire logic mem_req_i,
  input wire logic [OUTSTANDING_W-1:0] outstanding_i,
  input wire logic cmd_stream_busy_i,
  output logic arb_hold_o,
  output logic refresh_fetch_en_o,
  output logic cursor_fetch_en_o,
  output logic overlay_fetch_en_o,
  output logic s3_ready_o,
  output s3_pkg::sdram_pins_s sdram_o
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_DRAIN = 7'b0000010,
    ST_PRECHARGE = 7'b0000100,
    ST_WAIT_RP = 7'b0001000,
    ST_SELF_REFRESH = 7'b0010000,
    ST_SUSPENDED = 7'b0100000,
    ST_EXIT = 7'b1000000
  } quiesce_state_e;

  quiesce_state_e state;
  quiesce_state_e next_state;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser for the suspend request
  logic s3_meta;
  logic s3_sync;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s3_meta <= 1'b0;
      s3_sync <= 1'b0;
    end else begin
      s3_meta <= s3_req_i;
      s3_sync <= s3_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] seq_index;
  logic [7:0] sequencer_clocking_mode;
  logic [s3_pkg::DATA_W-1:0] overlay_control;
  logic [s3_pkg::DATA_W-1:0] hw_cursor_control;
  logic violation;
  logic gfx_live;

  function automatic logic hit(input s3_pkg::reg_req_s r, input logic [s3_pkg::ADDR_W-1:0] a);
    hit = (r.addr == a);
  endfunction : hit

  wire wr_index = reg_i.wr && hit(reg_i, s3_pkg::SEQ_INDEX_ADDR);
  wire wr_clocking = reg_i.wr && hit(reg_i, s3_pkg::SEQ_DATA_ADDR)
                     && (seq_index == s3_pkg::SEQ_IDX_CLOCKING_MODE);
  wire wr_overlay = reg_i.wr && hit(reg_i, s3_pkg::OVERLAY_CTL_ADDR);
  wire wr_cursor = reg_i.wr && hit(reg_i, s3_pkg::CURSOR_CTL_ADDR);
  wire wr_status = reg_i.wr && hit(reg_i, s3_pkg::QUIESCE_STATUS_ADDR);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      seq_index <= s3_pkg::SEQ_INDEX_RST;
      sequencer_clocking_mode <= s3_pkg::SEQ_CLOCKING_RST;
      overlay_control <= s3_pkg::OVERLAY_CTL_RST;
      hw_cursor_control <= s3_pkg::CURSOR_CTL_RST;
    end else begin
      if (wr_index) begin
        seq_index <= reg_i.wdata[7:0];
      end
      if (wr_clocking) begin
        sequencer_clocking_mode <= reg_i.wdata[7:0];
      end
      if (wr_overlay) begin
        overlay_control <= reg_i.wdata;
      end
      if (wr_cursor) begin
        hw_cursor_control <= reg_i.wdata;
      end
    end
  end

  wire [s3_pkg::DATA_W-1:0] status_word = {
    {(s3_pkg::DATA_W-4){1'b0}},
    gfx_live,
    violation,
    (state != ST_IDLE),
    (state == ST_SUSPENDED)
  };

  wire [s3_pkg::DATA_W-1:0] seq_data_word = (seq_index == s3_pkg::SEQ_IDX_CLOCKING_MODE) ?
                                            {24'h000000, sequencer_clocking_mode} : 32'h00000000;

  // unmapped addresses read as zero
  wire [s3_pkg::DATA_W-1:0] rd_mux =
    hit(reg_i, s3_pkg::SEQ_INDEX_ADDR) ? {24'h000000, seq_index} :
    hit(reg_i, s3_pkg::SEQ_DATA_ADDR) ? seq_data_word :
    hit(reg_i, s3_pkg::OVERLAY_CTL_ADDR) ? overlay_control :
    hit(reg_i, s3_pkg::CURSOR_CTL_ADDR) ? hw_cursor_control :
    hit(reg_i, s3_pkg::QUIESCE_STATUS_ADDR) ? status_word : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_i.rd) begin
      reg_rdata_o <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // graphics fetch enables
  wire refresh_on = !sequencer_clocking_mode[s3_pkg::SCREEN_OFF_BIT];
  wire cursor_on = hw_cursor_control[s3_pkg::CURSOR_MODE_LSB +: s3_pkg::CURSOR_MODE_W]
                   != s3_pkg::CURSOR_MODE_OFF;
  wire overlay_on = overlay_control[s3_pkg::OVERLAY_EN_BIT];
  wire gfx_any_on = refresh_on || cursor_on || overlay_on || cmd_stream_busy_i;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      refresh_fetch_en_o <= 1'b0;
      cursor_fetch_en_o <= 1'b0;
      overlay_fetch_en_o <= 1'b0;
    end else begin
      refresh_fetch_en_o <= refresh_on;
      cursor_fetch_en_o <= cursor_on;
      overlay_fetch_en_o <= overlay_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // entry / exit sequencer
  logic [s3_pkg::CNT_W-1:0] wait_cnt;
  wire wait_done = (wait_cnt == '0);
  wire drained = (outstanding_i == '0);
  wire entering = (state == ST_PRECHARGE) || (state == ST_WAIT_RP)
                  || (state == ST_SELF_REFRESH) || (state == ST_SUSPENDED);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (s3_sync) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!s3_sync) begin
          next_state = ST_IDLE;
        end else if (drained) begin
          next_state = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        next_state = ST_WAIT_RP;
      end
      ST_WAIT_RP: begin
        if (wait_done) begin
          next_state = ST_SELF_REFRESH;
        end
      end
      ST_SELF_REFRESH: begin
        next_state = ST_SUSPENDED;
      end
      ST_SUSPENDED: begin
        if (!s3_sync) begin
          next_state = ST_EXIT;
        end
      end
      ST_EXIT: begin
        if (wait_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // from precharge onward the arbiter is cut off from the pins, so a late graphics
  // activate cannot reopen a bank; the cost is that it is silently dropped
  wire s3_pkg::sdram_cmd_e seq_cmd =
    (state == ST_PRECHARGE) ? s3_pkg::SD_PRECHARGE_ALL :
    (state == ST_SELF_REFRESH) ? s3_pkg::SD_SELF_REFRESH_ENTER :
    (state == ST_SUSPENDED && !s3_sync) ? s3_pkg::SD_SELF_REFRESH_EXIT :
    (state == ST_IDLE || state == ST_DRAIN) ? arb_cmd_i : s3_pkg::SD_NOP;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      wait_cnt <= '0;
      arb_hold_o <= 1'b0;
      s3_ready_o <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_PRECHARGE) begin
        wait_cnt <= s3_pkg::CNT_W'(s3_pkg::TRP_CYC - 1);
      end else if (state == ST_SUSPENDED) begin
        wait_cnt <= s3_pkg::CNT_W'(s3_pkg::TXSR_CYC - 1);
      end else if (!wait_done) begin
        wait_cnt <= wait_cnt - 1'b1;
      end
      arb_hold_o <= (next_state != ST_IDLE);
      s3_ready_o <= (next_state == ST_SUSPENDED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status; a new event wins over a clear in the same cycle
  wire viol_event = entering && mem_req_i;
  wire live_event = (state == ST_IDLE) && s3_sync && gfx_any_on;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      violation <= 1'b0;
      gfx_live <= 1'b0;
    end else begin
      violation <= viol_event || (violation && !(wr_status && reg_i.wdata[s3_pkg::ST_VIOLATION_BIT]));
      gfx_live <= live_event || (gfx_live && !(wr_status && reg_i.wdata[s3_pkg::ST_GFX_LIVE_BIT]));
    end
  end

  sdram_cmd_gen u_cmd_gen (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .cmd_i(seq_cmd),
    .pins_o(sdram_o)
  );

endmodule : s3_quiesce

`default_nettype wire

// >>> common/s3_pkg.sv
`default_nettype none

package s3_pkg;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [ADDR_W-1:0] SEQ_INDEX_ADDR = 20'h003C4;
  localparam logic [ADDR_W-1:0] SEQ_DATA_ADDR = 20'h003C5;
  localparam logic [ADDR_W-1:0] OVERLAY_CTL_ADDR = 20'h00068;
  localparam logic [ADDR_W-1:0] CURSOR_CTL_ADDR = 20'h70080;
  localparam logic [ADDR_W-1:0] QUIESCE_STATUS_ADDR = 20'h000F0;

  localparam logic [7:0] SEQ_IDX_CLOCKING_MODE = 8'h01;
  localparam int SCREEN_OFF_BIT = 5;
  localparam int CURSOR_MODE_LSB = 0;
  localparam int CURSOR_MODE_W = 3;
  localparam logic [CURSOR_MODE_W-1:0] CURSOR_MODE_OFF = 3'h0;
  localparam int OVERLAY_EN_BIT = 0;

  localparam logic [7:0] SEQ_INDEX_RST = 8'h00;
  localparam logic [7:0] SEQ_CLOCKING_RST = 8'h00;
  localparam logic [DATA_W-1:0] OVERLAY_CTL_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] CURSOR_CTL_RST = 32'h00000000;

  // quiesce status fields
  localparam int ST_SUSPENDED_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_VIOLATION_BIT = 2;
  localparam int ST_GFX_LIVE_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ = 10;
  localparam int TRP_NS = 20;
  localparam int TXSR_NS = 70;
  localparam int TRP_CALC = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int TXSR_CALC = (TXSR_NS * CLK_MHZ + 999) / 1000;
  localparam int TRP_CYC = (TRP_CALC < 1) ? 1 : TRP_CALC;
  localparam int TXSR_CYC = (TXSR_CALC < 1) ? 1 : TXSR_CALC;
  localparam int CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    SD_NOP = 3'h0,
    SD_ACTIVATE = 3'h1,
    SD_READ = 3'h2,
    SD_WRITE = 3'h3,
    SD_PRECHARGE_ALL = 3'h4,
    SD_AUTO_REFRESH = 3'h5,
    SD_SELF_REFRESH_ENTER = 3'h6,
    SD_SELF_REFRESH_EXIT = 3'h7
  } sdram_cmd_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic a10;
  } sdram_pins_s;

endpackage : s3_pkg

`default_nettype wire

// >>> logic/sdram_cmd_gen.sv
`timescale 1ns/1ns
`default_nettype none

// turns a command code into registered sdram control pins; cke stays low from
// self-refresh entry until the exit command
module sdram_cmd_gen (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire s3_pkg::sdram_cmd_e cmd_i,
  output s3_pkg::sdram_pins_s pins_o
);

  s3_pkg::sdram_pins_s next_pins;

  always_comb begin
    next_pins = '{cke: pins_o.cke, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, a10: 1'b0};
    case (cmd_i)
      s3_pkg::SD_ACTIVATE: begin
        next_pins.ras_n = 1'b0;
      end
      s3_pkg::SD_READ: begin
        next_pins.cas_n = 1'b0;
      end
      s3_pkg::SD_WRITE: begin
        next_pins.cas_n = 1'b0;
        next_pins.we_n = 1'b0;
      end
      s3_pkg::SD_PRECHARGE_ALL: begin
        next_pins.ras_n = 1'b0;
        next_pins.we_n = 1'b0;
        next_pins.a10 = 1'b1;
      end
      s3_pkg::SD_AUTO_REFRESH: begin
        next_pins.ras_n = 1'b0;
        next_pins.cas_n = 1'b0;
      end
      s3_pkg::SD_SELF_REFRESH_ENTER: begin
        next_pins.ras_n = 1'b0;
        next_pins.cas_n = 1'b0;
        next_pins.cke = 1'b0;
      end
      s3_pkg::SD_SELF_REFRESH_EXIT: begin
        next_pins.cke = 1'b1;
      end
      default: begin
        next_pins.cs_n = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pins_o <= '{cke: 1'b1, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, a10: 1'b0};
    end else begin
      pins_o <= next_pins;
    end
  end

endmodule : sdram_cmd_gen

`default_nettype wire

// >>> bench/s3_quiesce_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module s3_quiesce_assertions #(
  parameter int OUTSTANDING_W = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic s3_req_i,
  input wire s3_pkg::reg_req_s reg_i,
  input wire logic [s3_pkg::DATA_W-1:0] reg_rdata_o,
  input wire s3_pkg::sdram_cmd_e arb_cmd_i,
  input wire logic mem_req_i,
  input wire logic [OUTSTANDING_W-1:0] outstanding_i,
  input wire logic cmd_stream_busy_i,
  input wire logic arb_hold_o,
  input wire logic refresh_fetch_en_o,
  input wire logic cursor_fetch_en_o,
  input wire logic overlay_fetch_en_o,
  input wire logic s3_ready_o,
  input wire s3_pkg::sdram_pins_s sdram_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire pre_w = !sdram_o.cs_n && !sdram_o.ras_n && sdram_o.cas_n && !sdram_o.we_n && sdram_o.a10;
  wire sr_w = !sdram_o.cke && !sdram_o.ras_n && !sdram_o.cas_n;
  wire act_w = !sdram_o.cs_n && !sdram_o.ras_n && sdram_o.cas_n && sdram_o.we_n;
  wire wr_seq_w = reg_i.wr && reg_i.addr == s3_pkg::SEQ_DATA_ADDR && reg_i.wdata[s3_pkg::SCREEN_OFF_BIT];
  wire wr_cur_w = reg_i.wr && reg_i.addr == s3_pkg::CURSOR_CTL_ADDR;
  wire wr_ovl_w = reg_i.wr && reg_i.addr == s3_pkg::OVERLAY_CTL_ADDR;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_pre;
    pre_w;
  endsequence
  sequence s_enter;
    ##[1:6] sr_w;
  endsequence
  property p_pre_then_sr;
    s_pre |-> s_enter;
  endproperty
  a_pre_then_sr: assert property (p_pre_then_sr) else $error("no self-refresh after precharge");
  property p_no_act;
    s_pre |=> (!act_w) [*3];
  endproperty
  a_no_act: assert property (p_no_act) else $error("activate after precharge");
  property p_ready_cke;
    s3_ready_o && $past(s3_ready_o) |-> !sdram_o.cke;
  endproperty
  a_ready_cke: assert property (p_ready_cke) else $error("suspended with cke high");
  property p_pre_drained;
    s_pre |-> $past(outstanding_i, 2) == '0 && arb_hold_o;
  endproperty
  a_pre_drained: assert property (p_pre_drained) else $error("precharge before drain");
  property p_refresh_off;
    $fell(refresh_fetch_en_o) |-> $past(wr_seq_w) || $past(wr_seq_w, 2);
  endproperty
  a_refresh_off: assert property (p_refresh_off) else $error("refresh stopped without write");
  property p_cursor_off;
    wr_cur_w && reg_i.wdata[s3_pkg::CURSOR_MODE_LSB +: s3_pkg::CURSOR_MODE_W] == s3_pkg::CURSOR_MODE_OFF
      |-> ##2 !cursor_fetch_en_o;
  endproperty
  a_cursor_off: assert property (p_cursor_off) else $error("cursor fetch still on");
  property p_overlay_off;
    wr_ovl_w && !reg_i.wdata[s3_pkg::OVERLAY_EN_BIT] |-> ##2 !overlay_fetch_en_o;
  endproperty
  a_overlay_off: assert property (p_overlay_off) else $error("overlay fetch still on");
endmodule : s3_quiesce_assertions
bind s3_quiesce s3_quiesce_assertions #(.OUTSTANDING_W(OUTSTANDING_W)) s3_quiesce_assertions_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .s3_req_i(s3_req_i), .reg_i(reg_i), .reg_rdata_o(reg_rdata_o),
  .arb_cmd_i(arb_cmd_i), .mem_req_i(mem_req_i), .outstanding_i(outstanding_i),
  .cmd_stream_busy_i(cmd_stream_busy_i), .arb_hold_o(arb_hold_o), .refresh_fetch_en_o(refresh_fetch_en_o),
  .cursor_fetch_en_o(cursor_fetch_en_o), .overlay_fetch_en_o(overlay_fetch_en_o),
  .s3_ready_o(s3_ready_o), .sdram_o(sdram_o));
`default_nettype wire

// >>> bench/sdram_model.sv
`timescale 1ns/1ns
`default_nettype none
// flags any self-refresh entry not preceded by precharge-all, or an activate in between
module sdram_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire s3_pkg::sdram_pins_s pins_i,
  output logic self_refresh_o,
  output logic bad_o
);
  logic pre_seen;
  wire pre_w = !pins_i.cs_n && !pins_i.ras_n && pins_i.cas_n && !pins_i.we_n && pins_i.a10;
  wire act_w = !pins_i.cs_n && !pins_i.ras_n && pins_i.cas_n && pins_i.we_n;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pre_seen <= 1'b0;
      self_refresh_o <= 1'b0;
      bad_o <= 1'b0;
    end else begin
      if (pre_w) pre_seen <= 1'b1;
      if (act_w && pre_seen) bad_o <= 1'b1;
      if (!pins_i.cke && !self_refresh_o) begin
        self_refresh_o <= 1'b1;
        pre_seen <= 1'b0;
        if (!pre_seen) bad_o <= 1'b1;
      end
      if (pins_i.cke) self_refresh_o <= 1'b0;
    end
  end
endmodule : sdram_model
`default_nettype wire

// >>> bench/tb_s3_quiesce.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_s3_quiesce;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic s3_req_i = 1'b0;
  logic mem_req_i = 1'b0;
  logic busy = 1'b0;
  logic [3:0] outstanding = 4'h0;
  s3_pkg::reg_req_s reg_i = '0;
  s3_pkg::sdram_cmd_e arb_cmd = s3_pkg::SD_NOP;
  s3_pkg::sdram_pins_s pins;
  logic [31:0] rdata;
  logic arb_hold, ref_en, cur_en, ovl_en, ready, sr, bad;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  always #50 clk_i = ~clk_i;
  s3_quiesce #(.OUTSTANDING_W(4)) s3_quiesce_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s3_req_i(s3_req_i),
    .reg_i(reg_i), .reg_rdata_o(rdata), .arb_cmd_i(arb_cmd), .mem_req_i(mem_req_i),
    .outstanding_i(outstanding), .cmd_stream_busy_i(busy), .arb_hold_o(arb_hold),
    .refresh_fetch_en_o(ref_en), .cursor_fetch_en_o(cur_en), .overlay_fetch_en_o(ovl_en),
    .s3_ready_o(ready), .sdram_o(pins));
  sdram_model sdram_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .pins_i(pins), .self_refresh_o(sr),
    .bad_o(bad));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge clk_i);
    #10 reg_i = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk_i);
    #10 reg_i = '0;
  endtask : acc
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    `CHK(rdata, e)
  endtask : rd
  task automatic tick;
    @(posedge clk_i);
    #10;
  endtask : tick
  task automatic wait_ready(input logic v);
    int n;
    n = 0;
    while (ready !== v && n < 40) begin
      tick();
      n++;
    end
    `CHK(ready, v)
  endtask : wait_ready
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    #10 sys_rst_i = 1'b0;
    tick();
    `CHK({ref_en, cur_en, ovl_en, arb_hold, ready}, 5'h10)
    rd(s3_pkg::SEQ_INDEX_ADDR, 32'h0);
    rd(s3_pkg::OVERLAY_CTL_ADDR, 32'h0);
    rd(s3_pkg::CURSOR_CTL_ADDR, 32'h0);
    rd(20'h12344, 32'h0);
    acc(1'b1, s3_pkg::SEQ_INDEX_ADDR, 32'h1);
    acc(1'b1, s3_pkg::SEQ_DATA_ADDR, 32'h20);
    tick();
    `CHK(ref_en, 1'b0)
    rd(s3_pkg::SEQ_DATA_ADDR, 32'h20);
    // other indices must not reach the screen-off bit
    acc(1'b1, s3_pkg::SEQ_INDEX_ADDR, 32'h2);
    acc(1'b1, s3_pkg::SEQ_DATA_ADDR, 32'h0);
    tick();
    `CHK(ref_en, 1'b0)
    acc(1'b1, s3_pkg::CURSOR_CTL_ADDR, 32'h5);
    tick();
    `CHK(cur_en, 1'b1)
    acc(1'b1, s3_pkg::CURSOR_CTL_ADDR, 32'h0);
    tick();
    `CHK(cur_en, 1'b0)
    acc(1'b1, s3_pkg::OVERLAY_CTL_ADDR, 32'h1);
    tick();
    `CHK(ovl_en, 1'b1)
    acc(1'b1, s3_pkg::OVERLAY_CTL_ADDR, 32'h0);
    tick();
    `CHK(ovl_en, 1'b0)
    // abort in drain: nothing may reach the sdram
    outstanding = 4'h2;
    busy = 1'b1;
    s3_req_i = 1'b1;
    repeat (6) tick();
    `CHK({arb_hold, ready}, 2'h2)
    s3_req_i = 1'b0;
    repeat (8) tick();
    `CHK({arb_hold, ready, sr}, 3'h0)
    // a live command streamer at the request leaves the sticky graphics flag
    busy = 1'b0;
    rd(s3_pkg::QUIESCE_STATUS_ADDR, 32'h8);
    acc(1'b1, s3_pkg::QUIESCE_STATUS_ADDR, 32'h8);
    rd(s3_pkg::QUIESCE_STATUS_ADDR, 32'h0);
    // arbiter keeps pushing activates while requests drain
    outstanding = 4'h3;
    arb_cmd = s3_pkg::SD_ACTIVATE;
    s3_req_i = 1'b1;
    repeat (10) tick();
    `CHK({arb_hold, ready, sr}, 3'h4)
    outstanding = 4'h0;
    wait_ready(1'b1);
    tick();
    `CHK({sr, bad}, 2'h2)
    rd(s3_pkg::QUIESCE_STATUS_ADDR, 32'h3);
    mem_req_i = 1'b1;
    tick();
    mem_req_i = 1'b0;
    rd(s3_pkg::QUIESCE_STATUS_ADDR, 32'h7);
    acc(1'b1, s3_pkg::QUIESCE_STATUS_ADDR, 32'h4);
    rd(s3_pkg::QUIESCE_STATUS_ADDR, 32'h3);
    s3_req_i = 1'b0;
    arb_cmd = s3_pkg::SD_NOP;
    wait_ready(1'b0);
    repeat (8) tick();
    `CHK({arb_hold, sr, bad}, 3'h0)
    rd(s3_pkg::QUIESCE_STATUS_ADDR, 32'h0);
    complete_run();
  end
endmodule : tb_s3_quiesce
`default_nettype wire
